// ### common/tir_pkg.sv
// Constants, types and register map of the tag command interpreter.
// Assumes an APB master with 8-bit byte addresses and 32-bit data.
package tir_pkg;
  // Command codes (arbitrary defaults)
  localparam logic [7:0] OP_COLLISION = 8'h01;
  localparam logic [7:0] OP_ADVANCE = 8'h02;
  localparam logic [7:0] OP_REPEAT_ID = 8'h03;
  localparam logic [7:0] OP_REINIT = 8'h04;
  localparam logic [7:0] OP_READ = 8'h10;
  localparam logic [7:0] OP_MULTI_READ = 8'h11;
  localparam logic [7:0] OP_IDENT_READ = 8'h12;
  localparam logic [7:0] OP_VERIFY_BYTE = 8'h13;
  localparam logic [7:0] OP_VERIFY_QUAD = 8'h14;
  // Register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ID_LO = 8'h04;
  localparam logic [7:0] REG_ID_HI = 8'h08;
  localparam logic [7:0] REG_ADDR = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  // Field positions
  localparam int F_ADDR_LSB = 0;
  localparam int F_MASK_LSB = 8;
  localparam int F_ST_LSB = 0;
  localparam int F_BUSY = 2;
  localparam int F_LWG = 3;
  localparam int F_CNT_LSB = 8;
  // Counts and reset values
  localparam logic [11:0] BLOCK_BYTES = 12'd8;
  localparam logic [11:0] BYTE_ONE = 12'd1;
  localparam logic [11:0] QUAD_BYTES = 12'd4;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [15:0] LFSR_RST = 16'hace1;
  typedef enum logic [1:0] {TS_READY, TS_IDENT, TS_XFER} tir_tag_state_t;
  typedef enum logic [1:0] {SQ_IDLE, SQ_LOAD, SQ_SEND} tir_seq_t;
  typedef struct packed {
    logic [63:0] id;
    logic [7:0] addr;
    logic [7:0] mask;
  } tir_cmd_t;
endpackage

// ### dv/tir_core_tb.sv
// Testbench: commands over APB, replies checked against the memory image or the serial number.
// Assumes tir_core, tir_peer and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tir_core_tb
  import tir_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, group_ident, tx_valid, lock_mark;
  logic [7:0] lock_mark_addr, lk_addr;
  int lk_cnt = 0;
  logic write_done, write_advance_command, tx_ready, tx_last, stall, pready, pslverr;
  logic [7:0] paddr, mem_addr, mem_rdata, tx_data;
  logic [31:0] pwdata, prdata, d;
  logic [63:0] sn = 64'h1122334455667788;
  int n_mismatch = 0;
  int cmp_count = 0;
  tir_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tag_serial_number(sn), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_last(tx_last), .lock_mark(lock_mark),
    .lock_mark_addr(lock_mark_addr),
    .write_done(write_done), .write_advance_command(write_advance_command),
    .group_ident(group_ident));
  tir_peer u_peer (.pclk(pclk), .presetn(presetn), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .stall(stall));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Records every lock mark pulse and the address it carries
  always @(posedge pclk) begin
    if (lock_mark) begin
      lk_cnt <= lk_cnt + 1;
      lk_addr <= lock_mark_addr;
    end
  end
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (!pready && k < 20);
    `CHK("pready", 1'b1, pready)
    if (!pready) end_sim();
    d = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] a,
                     input logic [7:0] m, input logic [63:0] id);
    int k;
    u_peer.q.delete();
    xfer(1'b1, REG_ID_LO, id[31:0]);
    xfer(1'b1, REG_ID_HI, id[63:32]);
    xfer(1'b1, REG_ADDR, {16'h0, m, a});
    xfer(1'b1, REG_CMD, {24'h0, op});
    k = 0;
    do begin
      xfer(1'b0, REG_STATUS, 32'h0);
      k++;
    end while (d[F_BUSY] !== 1'b0 && k < 200);
    if (d[F_BUSY] !== 1'b0) begin
      n_mismatch++;
      end_sim();
    end
  endtask
  task automatic chk(input int n, input logic [7:0] a, input logic sr);
    `CHK("reply length", n, u_peer.q.size())
    for (int i = 0; i < n && i < u_peer.q.size(); i++) begin
      if (sr) `CHK("serial byte", sn[63 - 8 * i -: 8], u_peer.q[i])
      else if (int'(a) + i <= 'hdf)
        `CHK("memory byte", 8'(a + i) ^ 8'h5a, u_peer.q[i])
    end
  endtask
  task automatic pulse(input logic gi, input logic ok);
    group_ident <= gi;
    write_done <= !gi;
    write_advance_command <= ok;
    @(posedge pclk);
    group_ident <= 1'b0;
    write_done <= 1'b0;
    xfer(1'b0, REG_STATUS, 32'h0);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, group_ident} = 5'h0;
    {write_done, write_advance_command, stall, paddr, pwdata} = 43'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, REG_STATUS, 32'h0);
    `CHK("status", 32'h0, d)
    xfer(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, d)
    $display("test reset done");
    pulse(1'b1, 1'b0);
    `CHK("state", 10'h001, {d[15:8], d[1:0]})
    cmd(OP_REPEAT_ID, 8'h0, 8'h0, sn);
    chk(8, 8'h0, 1'b1);
    cmd(OP_ADVANCE, 8'h0, 8'h0, sn);
    chk(8, 8'h0, 1'b1);
    for (int i = 0; i < 260; i++) cmd(OP_COLLISION, 8'h0, 8'h0, sn);
    `CHK("count", 8'hff, d[15:8])
    cmd(OP_ADVANCE, 8'h0, 8'h0, sn);
    chk(0, 8'h0, 1'b1);
    `CHK("count", 8'hfe, d[15:8])
    cmd(OP_REPEAT_ID, 8'h0, 8'h0, sn);
    chk(0, 8'h0, 1'b1);
    cmd(OP_REINIT, 8'h0, 8'h0, sn);
    chk(0, 8'h0, 1'b1);
    `CHK("state", 2'h0, d[1:0])
    $display("test identify done");
    cmd(OP_IDENT_READ, 8'h20, 8'h0, sn);
    chk(0, 8'h20, 1'b0);
    cmd(OP_READ, 8'h20, 8'h0, ~sn);
    chk(0, 8'h20, 1'b0);
    cmd(OP_READ, 8'h20, 8'h0, sn);
    chk(8, 8'h20, 1'b0);
    `CHK("lock addr", 8'h20, lk_addr)
    `CHK("state", 2'h2, d[1:0])
    cmd(OP_IDENT_READ, 8'h31, 8'h0, sn);
    chk(8, 8'h31, 1'b0);
    stall <= 1'b1;
    cmd(OP_MULTI_READ, 8'hd8, 8'h01, sn);
    chk(16, 8'hd8, 1'b0);
    `CHK("lock count", 2, lk_cnt)
    stall <= 1'b0;
    $display("test read done");
    cmd(OP_VERIFY_BYTE, 8'h44, 8'h0, sn);
    chk(0, 8'h44, 1'b0);
    pulse(1'b0, 1'b1);
    `CHK("write good", 1'b1, d[F_LWG])
    cmd(OP_VERIFY_BYTE, 8'h44, 8'h0, sn);
    chk(1, 8'h44, 1'b0);
    `CHK("lock addr", 8'h44, lk_addr)
    cmd(OP_VERIFY_QUAD, 8'h50, 8'ha0, sn);
    `CHK("quad length", 2, u_peer.q.size())
    `CHK("quad byte", 8'h52 ^ 8'h5a, u_peer.q[1])
    `CHK("lock count", 3, lk_cnt)
    pulse(1'b0, 1'b0);
    cmd(OP_VERIFY_QUAD, 8'h50, 8'hf0, sn);
    chk(0, 8'h50, 1'b0);
    $display("test verify done");
    end_sim();
  end
endmodule
`default_nettype wire

// ### dv/tir_peer.sv
// Far-side model: tag memory image and a stalling reply collector.
// Assumes combinational memory reads and the tx valid/ready handshake.
`timescale 1ns/1ps
`default_nettype none
module tir_peer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Memory and reply stream
  input wire logic [7:0] mem_addr,
  output logic [7:0] mem_rdata,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic stall
);
  logic [7:0] q[$];
  logic tog;
  assign mem_rdata = mem_addr ^ 8'h5a;
  assign tx_ready = !stall || tog;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog <= 1'b0;
    end else begin
      tog <= !tog;
      if (tx_valid && tx_ready) begin
        q.push_back(tx_data);
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/tir_props.sv
// Checker: port timing of the tag command interpreter.
// Assumes it is bound to tir_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module tir_props
  import tir_pkg::*;
(
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Reply stream and lock
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic lock_mark
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire cmd_wr = psel && penable && pwrite && paddr == REG_CMD;
  wire [7:0] op = pwdata[7:0];
  wire take = tx_valid && tx_ready;
  apb_ready_a: assert property (pready == (psel && penable))
    else $error("pready wrong");
  bad_addr_a: assert property (psel && penable && paddr > REG_STATUS
    |-> pslverr && prdata == 32'h0) else $error("unmapped access");
  lock_pulse_a: assert property (lock_mark |=> !lock_mark)
    else $error("lock mark too long");
  lock_cause_a: assert property (lock_mark |-> $past(cmd_wr &&
    (op == OP_READ || op == OP_IDENT_READ || op == OP_VERIFY_BYTE)))
    else $error("lock mark without read");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid &&
    $stable(tx_data) && $stable(tx_last)) else $error("byte dropped");
  tx_gap_a: assert property (take && !tx_last
    |=> !tx_valid ##[1:4] tx_valid) else $error("reply cut short");
  tx_end_a: assert property (take && tx_last |=> !tx_valid)
    else $error("reply runs on");
  reinit_quiet_a: assert property (cmd_wr && op == OP_REINIT &&
    !tx_valid |=> !tx_valid [*8]) else $error("reinit replied");
  cover property (lock_mark);
  cover property (take && tx_last);
  cover property (pslverr);
endmodule
bind tir_core tir_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
  .tx_last(tx_last), .lock_mark(lock_mark));
`default_nettype wire

// ### verilog/tir_core.sv
// Tag identification and read command interpreter with APB registers.
// Assumes combinational memory read and a byte reply sink with ready.
// Behaviour
// [R1] Collision: count +1 if nonzero or random bit set, saturates at FFh
// [R2] After collision or advance, serial number sent only when count is zero
// [R3] Advance: nonzero count drops by one, zero count stays
// [R4] Repeat: count untouched, serial number resent when count is zero
// [R5] Reinit: enter ready, clear transfer status, send nothing
// [R6] Basic read in any state: on serial match enter transfer, send 8 bytes
// [R7] Basic, identify and single-byte verify reads mark the address lockable
// [R8] Read commands stay silent on mismatch or unmet state or flag
// [R9] Multi-block read: on match enter transfer, send mask+1 8-byte blocks
// [R10] Multi-block read past DFh still runs; bytes beyond are undefined
// [R11] Identify-state read only in identify or transfer; match sends 8 bytes
// [R12] Single-byte verify needs match and last-write-good; sends one byte
// [R13] Quad verify needs match and last-write-good; sends four bytes (here only the offsets whose mask bit B7..B4 is set)
// [R14] Quad mask bit B7 selects offset 0, B6..B4 offsets 1..3
// [R15] Interrogator frames read: preamble, delimiter, code, id, address, CRC (here no frame decoding; code, id and address come in over APB registers)
// [R16] Last-write-good follows the outcome of each completed write
// [R17] Group selection into identify state clears the slot counter
// [R18] Opcodes and field positions are package constants
// [R19] Collision random bit comes from a per-tag pseudo-random source
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tir_core
  import tir_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Tag identity
  input wire logic [63:0] tag_serial_number,
  // Memory read port
  output logic [7:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  // Reply byte stream
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_last,
  // Lock preparation
  output logic lock_mark,
  output logic [7:0] lock_mark_addr,
  // Events from write and group select logic
  input wire logic write_done,
  input wire logic write_advance_command,
  input wire logic group_ident
);
  tir_tag_state_t tstate, next_tstate;
  tir_seq_t seq, next_seq;
  tir_cmd_t cmd, next_cmd;
  logic [7:0] count, next_count;
  logic [15:0] lfsr, next_lfsr;
  logic lwg, next_lwg;
  logic serial_src, next_serial_src;
  logic quad, next_quad;
  logic [11:0] rlen, next_rlen;
  logic [11:0] idx, next_idx;
  logic [7:0] next_tx_data;
  logic next_tx_last;
  logic next_lock_mark;
  logic [7:0] next_lock_mark_addr;
  logic [31:0] next_prdata;
  logic apb_setup, apb_wr, mapped, go, id_match, rnd;
  logic [7:0] op;
  logic [7:0] cnt_new;
  logic [3:0] qmask, qrest;

  assign apb_setup = psel && !penable;
  assign pready = psel && penable;
  assign mapped = (paddr == REG_CMD) || (paddr == REG_ID_LO) ||
                  (paddr == REG_ID_HI) || (paddr == REG_ADDR) ||
                  (paddr == REG_STATUS);
  assign pslverr = pready && !mapped;
  assign apb_wr = pready && pwrite && mapped;
  assign go = apb_wr && (paddr == REG_CMD) && (seq == SQ_IDLE);
  assign op = pwdata[7:0];
  assign id_match = (cmd.id == tag_serial_number);
  // Per-tag spread of the collision coin [R19]
  assign rnd = lfsr[0] ^ (^tag_serial_number);
  assign mem_addr = cmd.addr + idx[7:0];
  assign tx_valid = (seq == SQ_SEND);
  // Offset k is selected by mask bit 7-k [R14]
  assign qmask = cmd.mask[7:4];
  assign qrest = qmask << ({1'b0, idx[1:0]} + 3'd1);

  always_comb begin
    next_tstate = tstate;
    next_seq = seq;
    next_cmd = cmd;
    next_count = count;
    next_lfsr = lfsr;
    next_lwg = lwg;
    next_serial_src = serial_src;
    next_quad = quad;
    next_rlen = rlen;
    next_idx = idx;
    next_tx_data = tx_data;
    next_tx_last = tx_last;
    next_lock_mark = 1'b0;
    next_lock_mark_addr = lock_mark_addr;
    next_prdata = prdata;
    cnt_new = count;
    // Register reads are captured in the setup phase
    if (apb_setup) begin
      next_prdata = 32'h0000_0000;
      unique case (paddr)
        REG_ID_LO: next_prdata = cmd.id[31:0];
        REG_ID_HI: next_prdata = cmd.id[63:32];
        REG_ADDR: begin
          next_prdata[F_ADDR_LSB +: 8] = cmd.addr;
          next_prdata[F_MASK_LSB +: 8] = cmd.mask;
        end
        REG_STATUS: begin
          next_prdata[F_ST_LSB +: 2] = tstate;
          next_prdata[F_BUSY] = (seq != SQ_IDLE);
          next_prdata[F_LWG] = lwg;
          next_prdata[F_CNT_LSB +: 8] = count;
        end
        default: next_prdata = 32'h0000_0000;
      endcase
    end
    // Field writes are ignored while a reply is in progress
    if (apb_wr && (seq == SQ_IDLE)) begin
      if (paddr == REG_ID_LO) begin
        next_cmd.id[31:0] = pwdata;
      end
      if (paddr == REG_ID_HI) begin
        next_cmd.id[63:32] = pwdata;
      end
      if (paddr == REG_ADDR) begin
        next_cmd.addr = pwdata[F_ADDR_LSB +: 8];
        next_cmd.mask = pwdata[F_MASK_LSB +: 8];
      end
    end
    if (write_done) begin
      next_lwg = write_advance_command; // [R16]
    end
    if (group_ident) begin
      next_count = COUNT_RST; // [R17]
      next_tstate = TS_IDENT;
    end
    if (go) begin
      next_idx = 12'd0;
      next_quad = 1'b0;
      next_serial_src = 1'b0;
      unique case (op) // [R18]
        OP_COLLISION: begin
          if (tstate == TS_IDENT) begin
            next_lfsr = {lfsr[14:0],
                         lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]}; // [R19]
            if ((count != COUNT_RST) || rnd) begin
              cnt_new = (count == COUNT_MAX) ? COUNT_MAX : count + 8'd1; // [R1]
            end
            next_count = cnt_new;
            if (cnt_new == COUNT_RST) begin
              next_serial_src = 1'b1; // [R2]
              next_rlen = BLOCK_BYTES;
              next_seq = SQ_LOAD;
            end
          end
        end
        OP_ADVANCE: begin
          if (tstate == TS_IDENT) begin
            if (count != COUNT_RST) begin
              cnt_new = count - 8'd1; // [R3]
            end
            next_count = cnt_new;
            if (cnt_new == COUNT_RST) begin
              next_serial_src = 1'b1; // [R2]
              next_rlen = BLOCK_BYTES;
              next_seq = SQ_LOAD;
            end
          end
        end
        OP_REPEAT_ID: begin
          if ((tstate == TS_IDENT) && (count == COUNT_RST)) begin
            next_serial_src = 1'b1; // [R4]
            next_rlen = BLOCK_BYTES;
            next_seq = SQ_LOAD;
          end
        end
        OP_REINIT: begin
          next_tstate = TS_READY; // [R5]
        end
        OP_READ, OP_IDENT_READ: begin
          if (id_match && ((op == OP_READ) || (tstate != TS_READY))) begin
            next_tstate = TS_XFER; // [R6] [R11] [R8]
            next_rlen = BLOCK_BYTES;
            next_seq = SQ_LOAD;
            next_lock_mark = 1'b1; // [R7]
            next_lock_mark_addr = cmd.addr;
          end
        end
        OP_MULTI_READ: begin
          if (id_match) begin // [R8]
            next_tstate = TS_XFER;
            next_rlen = {({1'b0, cmd.mask} + 9'd1), 3'b000}; // [R9] [R10]
            next_seq = SQ_LOAD;
          end
        end
        OP_VERIFY_BYTE: begin
          if (id_match && lwg) begin // [R12] [R8]
            next_tstate = TS_XFER;
            next_rlen = BYTE_ONE;
            next_seq = SQ_LOAD;
            next_lock_mark = 1'b1; // [R7]
            next_lock_mark_addr = cmd.addr;
          end
        end
        OP_VERIFY_QUAD: begin
          if (id_match && lwg) begin // [R13] [R8]
            next_tstate = TS_XFER;
            next_rlen = QUAD_BYTES;
            next_quad = 1'b1;
            next_seq = SQ_LOAD;
          end
        end
        default: begin
        end
      endcase
    end
    unique case (seq)
      SQ_IDLE: begin
      end
      SQ_LOAD: begin
        if (idx >= rlen) begin
          next_seq = SQ_IDLE;
        end else if (quad && !qmask[3 - idx[1:0]]) begin
          next_idx = idx + 12'd1; // [R14]
        end else begin
          next_tx_data = serial_src ?
            tag_serial_number[8 * (7 - idx[2:0]) +: 8] : mem_rdata;
          next_tx_last = quad ? (qrest == 4'h0) : (idx == rlen - 12'd1);
          next_seq = SQ_SEND;
        end
      end
      SQ_SEND: begin
        if (tx_ready) begin
          next_idx = idx + 12'd1;
          next_seq = tx_last ? SQ_IDLE : SQ_LOAD;
        end
      end
      default: next_seq = SQ_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tstate <= TS_READY;
      seq <= SQ_IDLE;
      cmd <= '0;
      count <= COUNT_RST;
      lfsr <= LFSR_RST;
      lwg <= 1'b0;
      serial_src <= 1'b0;
      quad <= 1'b0;
      rlen <= 12'd0;
      idx <= 12'd0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
      lock_mark <= 1'b0;
      lock_mark_addr <= 8'h00;
      prdata <= 32'h0000_0000;
    end else begin
      tstate <= next_tstate;
      seq <= next_seq;
      cmd <= next_cmd;
      count <= next_count;
      lfsr <= next_lfsr;
      lwg <= next_lwg;
      serial_src <= next_serial_src;
      quad <= next_quad;
      rlen <= next_rlen;
      idx <= next_idx;
      tx_data <= next_tx_data;
      tx_last <= next_tx_last;
      lock_mark <= next_lock_mark;
      lock_mark_addr <= next_lock_mark_addr;
      prdata <= next_prdata;
    end
  end
endmodule
`default_nettype wire
